// File: src/upmux_port0.sv
`timescale 1ns/1ps
module upmux_port0 #(
  parameter int RST_FILTER_EDGES = upmux_pkg::RESET_FILTER_EDGES,
  parameter int FIFO_DEPTH       = upmux_pkg::TX_FIFO_DEPTH
) (
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic                        port0RecoveredClock,
  input  wire logic                        txClk,
  input  wire logic                        localSymbolClock,
  input  wire logic                        resetActiveLow,
  input  wire logic                        port0TxModeStrap,
  input  wire logic                        ledOnePin,
  input  wire logic                        port0SignalDetectIn,
  output logic                             rxDataValidOut,
  output logic                             rxDataValidOe,
  input  wire logic [upmux_pkg::NIB_W-1:0] port0ReceiveSymbol,
  input  wire logic                        port0ReceiveSymbolMsb,
  input  wire logic                        crsIn,
  output logic                             crsOut,
  output logic                             crsOe,
  input  wire logic                        colIn,
  output logic                             colOut,
  output logic                             colOe,
  output logic                             txEnOut,
  output logic [upmux_pkg::NIB_W-1:0]      transmitSymbol,
  output logic                             port0TransmitSymbolMsb,
  input  wire logic                        txWordValid,
  output logic                             txWordReady,
  input  wire logic [upmux_pkg::SYM_W-1:0] txWordSymbol,
  input  wire logic                        txWordEnable,
  input  wire logic                        txWordError,
  input  wire logic                        mediumRxActive,
  input  wire logic                        halfDuplex,
  output logic [upmux_pkg::SYM_W-1:0]      rxSymbol,
  output logic                             rxError,
  output logic                             rxStrobe,
  output logic                             port0SignalDetect,
  output logic                             phyCarrier,
  output logic                             phyCollision,
  output logic                             port0TxMode,
  output logic                             pcsType,
  output logic                             portInReset
);
  import upmux_pkg::*;

  localparam int FILT_W = $clog2(RST_FILTER_EDGES + 1);

  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [SYNC_W-1:0] syncPrev;
    logic [FILT_W-1:0] filtCount;
    logic              inReset;
    upmux_mode_t       mode;
    logic              txMode;
    logic              pcsMode;
    logic              rxdvOut;
    logic              rxdvOe;
    logic              crsOut;
    logic              crsOe;
    logic              colOut;
    logic              colOe;
    logic              txEn;
    logic [NIB_W-1:0]  txNib;
    logic              txMsb;
    logic [SYM_W-1:0]  rxSym;
    logic              rxErr;
    logic              rxStb;
    logic              sigDet;
    logic              phyCrs;
    logic              phyCol;
  } upmux_state_t;

  upmux_state_t      s;
  upmux_state_t      next_s;
  logic [SYNC_W-1:0] pinVec;
  logic              recRise;
  logic              txcRise;
  logic              locRise;
  logic              txRise;
  logic [TXW_W-1:0]  word;

  upmux_fifo_if #(.WIDTH(TXW_W)) fifoIf ();

  upmux_tx_fifo #(
    .WIDTH (TXW_W),
    .DEPTH (FIFO_DEPTH)
  ) txFifo (
    .clk  (clk),
    .nrst (nrst),
    .f    (fifoIf.store)
  );

  // Core side of the transmit store
  assign fifoIf.inValid = txWordValid;
  assign fifoIf.inData  = {txWordError, txWordEnable, txWordSymbol};
  assign txWordReady    = fifoIf.inReady;
  assign word           = fifoIf.outData;

  // Every pin and foreign clock enters through two flops
  assign pinVec = {colIn, crsIn, port0ReceiveSymbolMsb, port0ReceiveSymbol,
                   port0SignalDetectIn, ledOnePin, port0TxModeStrap,
                   resetActiveLow, localSymbolClock, txClk, port0RecoveredClock};

  assign recRise = s.sync2[I_REC] && !s.syncPrev[I_REC];
  assign txcRise = s.sync2[I_TXC] && !s.syncPrev[I_TXC];
  assign locRise = s.sync2[I_LOC] && !s.syncPrev[I_LOC];
  assign txRise  = (s.mode == UPMUX_TX) ? locRise : txcRise;

  always_comb begin
    logic en;
    logic err;
    en                = 1'b0;
    err               = 1'b0;
    next_s            = s;
    next_s.sync1      = pinVec;
    next_s.sync2      = s.sync1;
    next_s.syncPrev   = s.sync2;
    next_s.rxStb      = 1'b0;
    fifoIf.outReady   = 1'b0;
    // Reset pin must stay low over several local clock edges
    if (s.sync2[I_RST]) begin
      next_s.filtCount = '0;
      next_s.inReset   = 1'b0;
    end else if (locRise) begin
      if (s.filtCount == FILT_W'(RST_FILTER_EDGES - 1)) begin
        next_s.inReset = 1'b1;
      end else begin
        next_s.filtCount = s.filtCount + 1'b1;
      end
    end
    // Straps are caught only at release and held until the next reset
    if (s.inReset && !next_s.inReset) begin
      if (s.sync2[I_STX]) begin
        next_s.mode = UPMUX_TX;
      end else if (s.sync2[I_STY]) begin
        next_s.mode = UPMUX_PCS;
      end else begin
        next_s.mode = UPMUX_MAC;
      end
    end
    next_s.txMode  = (next_s.mode == UPMUX_TX);
    next_s.pcsMode = (next_s.mode == UPMUX_PCS);
    if (s.inReset) begin
      next_s.rxdvOut = 1'b0;
      next_s.rxdvOe  = 1'b0;
      next_s.crsOut  = 1'b0;
      next_s.crsOe   = 1'b0;
      next_s.colOut  = 1'b0;
      next_s.colOe   = 1'b0;
      next_s.txEn    = 1'b0;
      next_s.txNib   = '0;
      next_s.txMsb   = 1'b0;
      next_s.sigDet  = 1'b0;
      next_s.phyCrs  = 1'b0;
      next_s.phyCol  = 1'b0;
    end else begin
      next_s.rxdvOe = (s.mode != UPMUX_TX);
      next_s.crsOe  = (s.mode == UPMUX_PCS);
      next_s.colOe  = (s.mode == UPMUX_PCS);
      next_s.sigDet = (s.mode == UPMUX_TX) && s.sync2[I_SIG];
      next_s.phyCrs = (s.mode == UPMUX_MAC) && s.sync2[I_CRS];
      next_s.phyCol = (s.mode == UPMUX_MAC) && s.sync2[I_COL];
      if (recRise) begin
        next_s.rxStb = 1'b1;
        if (s.mode == UPMUX_TX) begin
          next_s.rxSym = {s.sync2[I_RD4], s.sync2[I_RD +: NIB_W]};
          next_s.rxErr = 1'b0;
        end else begin
          next_s.rxSym = {1'b0, s.sync2[I_RD +: NIB_W]};
          next_s.rxErr = s.sync2[I_RD4];
        end
      end
      if (txRise) begin
        fifoIf.outReady = 1'b1;
        case (s.mode)
          UPMUX_TX: begin
            if (fifoIf.outValid) begin
              next_s.txNib = word[TXW_SYM +: NIB_W];
              next_s.txMsb = word[TXW_SYM + NIB_W];
            end else begin
              next_s.txNib = IDLE_SYMBOL[NIB_W-1:0];
              next_s.txMsb = IDLE_SYMBOL[SYM_W-1];
            end
            next_s.txEn    = 1'b0;
            next_s.rxdvOut = 1'b0;
            next_s.crsOut  = 1'b0;
            next_s.colOut  = 1'b0;
          end
          UPMUX_PCS, UPMUX_MAC: begin
            en  = fifoIf.outValid && word[TXW_EN];
            err = en && word[TXW_ERR];
            if (err) begin
              next_s.txNib = HALT_SYMBOL[NIB_W-1:0];
            end else if (en) begin
              next_s.txNib = word[TXW_SYM +: NIB_W];
            end else begin
              next_s.txNib = MII_IDLE_NIBBLE;
            end
            next_s.txMsb   = err;
            next_s.txEn    = en;
            next_s.rxdvOut = en;
            if (s.mode == UPMUX_PCS) begin
              next_s.crsOut = mediumRxActive || (en && halfDuplex);
              next_s.colOut = mediumRxActive && en;
            end else begin
              next_s.crsOut = 1'b0;
              next_s.colOut = 1'b0;
            end
          end
          default: begin
            next_s.txEn = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s         <= '0;
      s.inReset <= 1'b1;
      s.mode    <= UPMUX_TX;
      s.txMode  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rxDataValidOut         = s.rxdvOut;
  assign rxDataValidOe          = s.rxdvOe;
  assign crsOut                 = s.crsOut;
  assign crsOe                  = s.crsOe;
  assign colOut                 = s.colOut;
  assign colOe                  = s.colOe;
  assign txEnOut                = s.txEn;
  assign transmitSymbol         = s.txNib;
  assign port0TransmitSymbolMsb = s.txMsb;
  assign rxSymbol               = s.rxSym;
  assign rxError                = s.rxErr;
  assign rxStrobe               = s.rxStb;
  assign port0SignalDetect      = s.sigDet;
  assign phyCarrier             = s.phyCrs;
  assign phyCollision           = s.phyCol;
  assign port0TxMode            = s.txMode;
  assign pcsType                = s.pcsMode;
  assign portInReset            = s.inReset;

  sequence running_s;
    !s.inReset && !$past(s.inReset);
  endsequence

  sequence recEdge_s;
    !s.inReset && recRise;
  endsequence

  sequence filterDone_s;
    !s.sync2[I_RST] && locRise && s.filtCount == FILT_W'(RST_FILTER_EDGES - 1);
  endsequence

  rxdvDirection_a: assert property (@(posedge clk) disable iff (!nrst)
    running_s |-> s.rxdvOe == (s.mode != UPMUX_TX) && !(s.rxdvOe && s.sigDet))
    else $error("rxdv pin direction disagrees with mode");

  rxSample_a: assert property (@(posedge clk) disable iff (!nrst)
    recEdge_s |=> s.rxStb && s.rxSym[NIB_W-1:0] == $past(s.sync2[I_RD +: NIB_W]))
    else $error("receive nibble not taken on recovered clock edge");

  rxErrLine_a: assert property (@(posedge clk) disable iff (!nrst)
    recEdge_s ##0 (s.mode != UPMUX_TX) |=>
      s.rxErr == $past(s.sync2[I_RD4]) && !s.rxSym[SYM_W-1])
    else $error("fifth receive line not steered to rx error");

  crsOwner_a: assert property (@(posedge clk) disable iff (!nrst)
    running_s |-> s.crsOe == (s.mode == UPMUX_PCS) && (s.crsOe || !s.crsOut))
    else $error("crs driven outside pcs type");

  txEnTiming_a: assert property (@(posedge clk) disable iff (!nrst)
    ($changed(s.txEn) && !$past(s.inReset)) |-> $past(txcRise) && s.mode != UPMUX_TX)
    else $error("txen changed away from txclk edge");

  txSymTiming_a: assert property (@(posedge clk) disable iff (!nrst)
    (s.mode == UPMUX_TX && $changed(s.txNib) && !$past(s.inReset)) |-> $past(locRise))
    else $error("tx symbol changed away from local clock edge");

  haltOnError_a: assert property (@(posedge clk) disable iff (!nrst)
    (s.txEn && s.txMsb && s.mode != UPMUX_TX) |-> s.txNib == HALT_SYMBOL[NIB_W-1:0])
    else $error("halt missing while tx error asserted");

  colCause_a: assert property (@(posedge clk) disable iff (!nrst)
    s.colOut |-> s.txEn && s.colOe && s.mode == UPMUX_PCS)
    else $error("collision driven without transmit enable");

  resetFilter_a: assert property (@(posedge clk) disable iff (!nrst)
    filterDone_s ##0 !s.inReset |=> s.inReset)
    else $error("filtered reset not entered");

  strapCapture_a: assert property (@(posedge clk) disable iff (!nrst)
    $fell(s.inReset) |-> s.mode == ($past(s.sync2[I_STX]) ? UPMUX_TX :
                        ($past(s.sync2[I_STY]) ? UPMUX_PCS : UPMUX_MAC)))
    else $error("strap not captured at reset release");

  strapHold_a: assert property (@(posedge clk) disable iff (!nrst)
    running_s |-> $stable(s.mode))
    else $error("port mode changed outside reset");

endmodule : upmux_port0

// File: shared/upmux_pkg.sv
package upmux_pkg;

  // Data widths
  localparam int NIB_W = 4;
  localparam int SYM_W = 5;

  // Transmit word from the repeater core: symbol, enable, error
  localparam int TXW_SYM = 0;
  localparam int TXW_EN  = 5;
  localparam int TXW_ERR = 6;
  localparam int TXW_W   = 7;

  // Transmit FIFO depth
  localparam int TX_FIFO_DEPTH = 16;

  // Local symbol clock edges the reset pin must stay low
  localparam int RESET_FILTER_EDGES = 4;

  // Line codes
  localparam logic [SYM_W-1:0] HALT_SYMBOL     = 5'h04;
  localparam logic [SYM_W-1:0] IDLE_SYMBOL     = 5'h1F;
  localparam logic [NIB_W-1:0] MII_IDLE_NIBBLE = 4'h0;

  // Bit positions in the synchroniser vector
  localparam int I_REC  = 0;
  localparam int I_TXC  = 1;
  localparam int I_LOC  = 2;
  localparam int I_RST  = 3;
  localparam int I_STX  = 4;
  localparam int I_STY  = 5;
  localparam int I_SIG  = 6;
  localparam int I_RD   = 7;
  localparam int I_RD4  = 11;
  localparam int I_CRS  = 12;
  localparam int I_COL  = 13;
  localparam int SYNC_W = 14;

  // Port 0 personality
  typedef enum logic [1:0] {
    UPMUX_TX,
    UPMUX_PCS,
    UPMUX_MAC
  } upmux_mode_t;

endpackage : upmux_pkg

// File: shared/upmux_fifo_if.sv
`timescale 1ns/1ps
interface upmux_fifo_if #(
  parameter int WIDTH = 8
);
  logic             inValid;
  logic             inReady;
  logic [WIDTH-1:0] inData;
  logic             outValid;
  logic             outReady;
  logic [WIDTH-1:0] outData;

  modport store (
    input  inValid,
    input  inData,
    input  outReady,
    output inReady,
    output outValid,
    output outData
  );

  modport user (
    output inValid,
    output inData,
    output outReady,
    input  inReady,
    input  outValid,
    input  outData
  );
endinterface : upmux_fifo_if

// File: src/upmux_tx_fifo.sv
`timescale 1ns/1ps
module upmux_tx_fifo #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 16
) (
  input wire logic    clk,
  input wire logic    nrst,
  upmux_fifo_if.store f
);
  import upmux_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [AW:0]                 cnt;
    logic                        notFull;
  } upmux_fifo_state_t;

  upmux_fifo_state_t s;
  upmux_fifo_state_t next_s;
  logic              push;
  logic              pop;

  assign push       = f.inValid && s.notFull;
  assign pop        = f.outReady && (s.cnt != '0);
  assign f.inReady  = s.notFull;
  assign f.outValid = (s.cnt != '0);
  assign f.outData  = s.mem[s.rd];

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr] = f.inData;
      next_s.wr        = s.wr + 1'b1;
    end
    if (pop) begin
      next_s.rd = s.rd + 1'b1;
    end
    if (push && !pop) begin
      next_s.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      next_s.cnt = s.cnt - 1'b1;
    end
    next_s.notFull = (next_s.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s         <= '0;
      s.notFull <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Occupancy never passes the depth
  fifoBound_a: assert property (@(posedge clk) disable iff (!nrst)
    s.cnt <= (AW+1)'(DEPTH) && (s.notFull == (s.cnt != (AW+1)'(DEPTH))))
    else $error("fifo occupancy out of range");

  // A push into a non-full store raises the count unless a pop balances it
  fifoCount_a: assert property (@(posedge clk) disable iff (!nrst)
    (push && !pop) |=> s.cnt == $past(s.cnt) + 1'b1)
    else $error("fifo count did not advance on push");

endmodule : upmux_tx_fifo

// File: dv/upmux_far_end.sv
`timescale 1ns/1ps
module upmux_far_end (
  input  wire logic                        macType,
  input  wire logic                        crsLevel,
  input  wire logic                        colLevel,
  output logic                             txClk,
  output logic                             recClk,
  output logic [upmux_pkg::SYM_W-1:0]      rxLines,
  output logic                             crsDrive,
  output logic                             colDrive,
  output logic [upmux_pkg::SYM_W-1:0]      lastSym
);
  import upmux_pkg::*;
  initial begin
    txClk = 1'b0;
    #13;
    forever #32 txClk = ~txClk;
  end
  // Receive lines change mid-period, clear of the recovered clock rise
  initial begin
    recClk = 1'b0;
    rxLines = 5'h00;
    lastSym = 5'h00;
    #7;
    forever begin
      #32 recClk = 1'b1;
      lastSym = rxLines;
      #32 recClk = 1'b0;
      rxLines = 5'($urandom);
    end
  end
  // Outside MAC type the released lines show the inverse level
  assign crsDrive = macType ? crsLevel : ~crsLevel;
  assign colDrive = macType ? colLevel : ~colLevel;
endmodule : upmux_far_end

// File: dv/universal_port_mii_tx_mux_test.sv
`timescale 1ns/1ps
module universal_port_mii_tx_mux_test;
  import upmux_pkg::*;
  logic       clk, nrst, port0RecoveredClock, txClk, localSymbolClock, resetActiveLow;
  logic       port0TxModeStrap, ledOnePin, port0SignalDetectIn, rxDataValidOut, rxDataValidOe;
  logic [3:0] port0ReceiveSymbol, transmitSymbol;
  logic       port0ReceiveSymbolMsb, crsIn, crsOut, crsOe, colIn, colOut, colOe, txEnOut;
  logic       port0TransmitSymbolMsb, txWordValid, txWordReady, txWordEnable, txWordError;
  logic [4:0] txWordSymbol, rxSymbol, rxLines, lastSym;
  logic       mediumRxActive, halfDuplex, rxError, rxStrobe, port0SignalDetect;
  logic       phyCarrier, phyCollision, port0TxMode, pcsType, portInReset;
  logic       sigDet, crsLvl, colLvl, crsDrv, colDrv, mon, started;
  int         errCount, nCompared, rxCount;
  int         q[$];

  upmux_port0 #(.RST_FILTER_EDGES(2), .FIFO_DEPTH(TX_FIFO_DEPTH)) dut (
    .clk, .nrst, .port0RecoveredClock, .txClk, .localSymbolClock, .resetActiveLow,
    .port0TxModeStrap, .ledOnePin, .port0SignalDetectIn, .rxDataValidOut, .rxDataValidOe,
    .port0ReceiveSymbol, .port0ReceiveSymbolMsb, .crsIn, .crsOut, .crsOe, .colIn, .colOut,
    .colOe, .txEnOut, .transmitSymbol, .port0TransmitSymbolMsb, .txWordValid, .txWordReady,
    .txWordSymbol, .txWordEnable, .txWordError, .mediumRxActive, .halfDuplex, .rxSymbol,
    .rxError, .rxStrobe, .port0SignalDetect, .phyCarrier, .phyCollision, .port0TxMode,
    .pcsType, .portInReset
  );
  upmux_far_end far (
    .macType(!port0TxMode && !pcsType), .crsLevel(crsLvl), .colLevel(colLvl), .txClk(txClk),
    .recClk(port0RecoveredClock), .rxLines(rxLines), .crsDrive(crsDrv), .colDrive(colDrv),
    .lastSym(lastSym)
  );
  assign port0ReceiveSymbol = rxLines[3:0];
  assign port0ReceiveSymbolMsb = rxLines[4];
  assign port0SignalDetectIn = rxDataValidOe ? rxDataValidOut : sigDet;
  assign crsIn = crsOe ? crsOut : crsDrv;
  assign colIn = colOe ? colOut : colDrv;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errCount++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // Model of the transmit side: one queued word per link edge, idle when empty
  task automatic sample_tx;
    int w;
    logic [4:0] s;
    logic en, er;
    if (portInReset !== 1'b0) return;
    // Nothing pops until the full store first makes room
    if (!started && txWordReady !== 1'b1) return;
    started = 1'b1;
    w = (q.size() > 0) ? q.pop_front() : -1;
    en = (w >= 0);
    er = en && w[6];
    s = en ? w[4:0] : IDLE_SYMBOL;
    if (port0TxMode) begin
      check({port0TransmitSymbolMsb, transmitSymbol}, s);
    end else begin
      check(txEnOut, en);
      check(rxDataValidOut, en);
      check(transmitSymbol, !en ? MII_IDLE_NIBBLE : er ? HALT_SYMBOL[3:0] : s[3:0]);
      check(port0TransmitSymbolMsb, er);
      check(crsOut, pcsType & (mediumRxActive | (en & halfDuplex)));
      check(colOut, pcsType & mediumRxActive & en);
    end
  endtask : sample_tx

  // One watcher per link clock, so a mode change makes no false edge
  initial forever begin
    @(posedge localSymbolClock);
    repeat (6) @(posedge clk);
    if (mon && port0TxMode === 1'b1) sample_tx();
  end
  initial forever begin
    @(posedge txClk);
    repeat (6) @(posedge clk);
    if (mon && port0TxMode === 1'b0) sample_tx();
  end

  always @(posedge clk) begin
    if (mon && rxStrobe === 1'b1) begin
      rxCount++;
      check(rxSymbol, port0TxMode ? lastSym : {1'b0, lastSym[3:0]});
      check(rxError, !port0TxMode & lastSym[4]);
    end
  end

  task automatic run_mode(input int m);
    int acc;
    logic [6:0] w;
    acc = 0;
    port0TxModeStrap <= (m == 0);
    ledOnePin <= (m == 1);
    {halfDuplex, mediumRxActive, sigDet, crsLvl, colLvl} <= 5'($urandom);
    resetActiveLow <= 1'b0;
    repeat (40) @(posedge clk);
    check(portInReset, 1'b1);
    for (int i = 0; i < 20; i++) begin
      w = {1'($urandom), 1'b1, 5'($urandom)};
      if (m == 0 && w[4:0] == IDLE_SYMBOL) w[0] = 1'b0;
      txWordValid <= 1'b1;
      {txWordError, txWordEnable, txWordSymbol} <= w;
      @(posedge clk);
      if (txWordReady === 1'b1) begin
        q.push_back(int'(w));
        acc++;
      end
    end
    txWordValid <= 1'b0;
    check(acc, TX_FIFO_DEPTH);
    check(txWordReady, 1'b0);
    started = 1'b0;
    rxCount = 0;
    mon = 1'b1;
    resetActiveLow <= 1'b1;
    for (acc = 0; acc < 100 && portInReset !== 1'b0; acc++) @(posedge clk);
    check(portInReset, 1'b0);
    @(posedge clk);
    check(port0TxMode, m == 0);
    check(pcsType, m == 1);
    port0TxModeStrap <= (m != 0);
    ledOnePin <= (m != 1);
    repeat (200) @(posedge clk);
    mon = 1'b0;
    check(q.size(), 0);
    check({port0TxMode, pcsType}, {m == 0, m == 1});
    check(rxCount > 10, 1'b1);
    check(rxDataValidOe, m != 0);
    check(port0SignalDetect, (m == 0) & sigDet);
    check({crsOe, colOe}, {m == 1, m == 1});
    check({phyCarrier, phyCollision}, {(m == 2) & crsLvl, (m == 2) & colLvl});
    $display("Mode test %0d done", m);
  endtask : run_mode

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    localSymbolClock = 1'b0;
    #21;
    forever #32 localSymbolClock = ~localSymbolClock;
  end
  initial begin
    #100000;
    errCount++;
    $display("MISMATCH at %0t: run did not finish", $time);
    wrap_up();
  end

  initial begin
    errCount = 0;
    nCompared = 0;
    mon = 1'b0;
    nrst = 1'b0;
    resetActiveLow = 1'b0;
    {port0TxModeStrap, ledOnePin, sigDet, crsLvl, colLvl} = 5'h00;
    {txWordValid, txWordEnable, txWordError, txWordSymbol} = 8'h00;
    {mediumRxActive, halfDuplex} = 2'h0;
    void'($urandom(40812));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    for (int m = 0; m < 3; m++) run_mode(m);
    resetActiveLow <= 1'b0;
    repeat (6) @(posedge clk);
    resetActiveLow <= 1'b1;
    repeat (30) @(posedge clk);
    check(portInReset, 1'b0);
    $display("Glitch test done");
    wrap_up();
  end
endmodule : universal_port_mii_tx_mux_test
